// [rtl/ahp_map.vh]
// ahp_map.vh: constants for the host read port of the controller
// assumes inclusion by rtl and bench modules; definitions only
`ifndef AHP_MAP_VH
`define AHP_MAP_VH
// word offsets on the host address (address[7:2] style index)
`define AHP_OFF_CHIP_ID 6'h14
`define AHP_OFF_ENDIAN 6'h19
`define AHP_OFF_IRQ_CFG 6'h15
`define AHP_OFF_INT_FLAGS 6'h16
`define AHP_OFF_RX_FILL 6'h1F
`define AHP_OFF_TX_FILL 6'h20
`define AHP_OFF_PWR_CTRL 6'h21
`define AHP_OFF_GPT_COUNT 6'h24
`define AHP_OFF_FREE_CNT 6'h27
`define AHP_OFF_DROP_CNT 6'h28
`define AHP_OFF_RX_DATA 6'h00
`define AHP_OFF_RX_STAT 6'h10
`define AHP_OFF_TX_STAT 6'h12
// fixed read value of the endian probe word; the pattern is arbitrary
`define AHP_ENDIAN_VAL 32'h0F1E2D3C
// burst limits in accesses
`define AHP_BURST_MAX32 5'h08
`define AHP_BURST_MAX16 5'h10
// timing, ns and clock period in ns
`define AHP_CLK_NS 50
`define AHP_TX_FILL_NS 135
`define AHP_TX_FILL_CYC ((`AHP_TX_FILL_NS) / (`AHP_CLK_NS))
`endif

// [rtl/ahp_fifo.v]
// ahp_fifo.v: synchronous valid/ready fifo, width and depth parameters
// assumes one clock, asynchronous active-high reset, depth a power of two
`timescale 1ns/10ps
`default_nettype none
module ahp_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_r;
  reg [AW:0] rp_r;
  wire do_wr;
  wire do_rd;
  assign level = wp_r - rp_r;
  assign in_ready = (level != DEPTH[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data = mem[rp_r[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always @(posedge clk) begin
    if (do_wr) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + {{AW{1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rp_r <= rp_r + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/ahp_port.v]
// ahp_port.v: device side of the sram-like programmed-io read port
// assumes strobes already synchronous to clk; the register set lives
// outside and is presented as plain value inputs
`timescale 1ns/10ps
`default_nettype none
`include "ahp_map.vh"
module ahp_port #(
  parameter DW = 32,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire clk,
  input wire rst,
  input wire chip_select_low,
  input wire read_strobe_low,
  input wire write_strobe_low,
  input wire [5:0] addr,
  input wire bus16,
  input wire [DW-1:0] data_in,
  output reg [DW-1:0] data_out,
  output wire [DW-1:0] data_oe,
  input wire rx_in_valid,
  output wire rx_in_ready,
  input wire [DW-1:0] rx_in_data,
  input wire [DW-1:0] rx_status_word,
  input wire [DW-1:0] tx_status_word,
  output reg rx_status_pop,
  output reg tx_status_pop,
  output reg tx_data_push,
  output reg [DW-1:0] tx_data_word,
  input wire [15:0] tx_free_space,
  input wire [DW-1:0] chip_identity,
  input wire [DW-1:0] irq_line_config,
  input wire [DW-1:0] interrupt_flags,
  input wire [DW-1:0] power_manage_control,
  input wire [DW-1:0] general_timer_count,
  input wire [DW-1:0] free_counter,
  input wire [DW-1:0] dropped_frame_counter,
  output reg [DW-1:0] transmit_fill_info,
  output reg burst_overrun
);
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_WRITE = 3'b100;
  localparam integer TXF_CYC = (`AHP_TX_FILL_CYC < 1) ? 1 : `AHP_TX_FILL_CYC;
  // the edge that sees the push is already the first cycle of the wait
  localparam integer TXF_LOAD = TXF_CYC - 1;

  reg [2:0] state_r;
  reg [4:0] beat_r;
  reg [5:0] addr_r;
  reg rd_hi_r;
  reg [DW-1:0] ctr_free_r;
  reg [DW-1:0] ctr_gpt_r;
  reg [DW-1:0] ctr_drop_r;
  reg [DW-1:0] rd_val;
  reg [3:0] txf_wait_r;
  reg txf_pend_r;
  wire rd_act;
  wire wr_act;
  wire rd_start;
  wire addr_step;
  wire rx_out_valid;
  wire rx_out_ready;
  wire [DW-1:0] rx_out_data;
  wire [FIFO_AW:0] rx_level;
  wire [4:0] beat_max;

  // ------------------------------------------------------------
  // cycle framing
  // ------------------------------------------------------------
  assign rd_act = !chip_select_low && !read_strobe_low;
  assign wr_act = !chip_select_low && !write_strobe_low;
  assign rd_start = rd_act && (state_r != ST_READ);
  assign addr_step = rd_act && (state_r == ST_READ) && (addr != addr_r);
  assign beat_max = bus16 ? `AHP_BURST_MAX16 : `AHP_BURST_MAX32;

  ahp_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data(rx_in_data),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(rx_out_data),
    .level(rx_level)
  );

  // one fifo word per read access; a halfword pair pops on the upper half
  assign rx_out_ready = (rd_start || addr_step) && (addr == `AHP_OFF_RX_DATA)
    && (!bus16 || rd_hi_r);

  // ------------------------------------------------------------
  // read data selection
  // ------------------------------------------------------------
  always @* begin
    rd_val = {DW{1'b0}};
    case (addr)
      `AHP_OFF_RX_DATA: rd_val = rx_out_valid ? rx_out_data : {DW{1'b0}};
      `AHP_OFF_RX_STAT: rd_val = rx_status_word;
      `AHP_OFF_TX_STAT: rd_val = tx_status_word;
      `AHP_OFF_CHIP_ID: rd_val = chip_identity;
      `AHP_OFF_ENDIAN: rd_val = `AHP_ENDIAN_VAL;
      `AHP_OFF_IRQ_CFG: rd_val = irq_line_config;
      `AHP_OFF_INT_FLAGS: rd_val = interrupt_flags;
      `AHP_OFF_RX_FILL: rd_val = {{(DW-FIFO_AW-1){1'b0}}, rx_level};
      `AHP_OFF_TX_FILL: rd_val = transmit_fill_info;
      `AHP_OFF_PWR_CTRL: rd_val = power_manage_control;
      `AHP_OFF_GPT_COUNT: rd_val = rd_start ? general_timer_count : ctr_gpt_r;
      `AHP_OFF_FREE_CNT: rd_val = rd_start ? free_counter : ctr_free_r;
      `AHP_OFF_DROP_CNT: rd_val = rd_start ? dropped_frame_counter : ctr_drop_r;
      default: rd_val = {DW{1'b0}};
    endcase
  end

  // upper lanes stay released on a 16-bit access
  assign data_oe = (state_r == ST_READ) ?
    (bus16 ? {{(DW/2){1'b0}}, {(DW/2){1'b1}}} : {DW{1'b1}}) : {DW{1'b0}};

  // ------------------------------------------------------------
  // cycle state machine
  // ------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      beat_r <= 5'h0;
      addr_r <= 6'h0;
      rd_hi_r <= 1'b0;
      data_out <= {DW{1'b0}};
      ctr_free_r <= {DW{1'b0}};
      ctr_gpt_r <= {DW{1'b0}};
      ctr_drop_r <= {DW{1'b0}};
      rx_status_pop <= 1'b0;
      tx_status_pop <= 1'b0;
      tx_data_push <= 1'b0;
      tx_data_word <= {DW{1'b0}};
      burst_overrun <= 1'b0;
    end else begin
      rx_status_pop <= 1'b0;
      tx_status_pop <= 1'b0;
      tx_data_push <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (rd_act) begin
            state_r <= ST_READ;
            addr_r <= addr;
            beat_r <= 5'h1;
            burst_overrun <= 1'b0;
            ctr_free_r <= free_counter;
            ctr_gpt_r <= general_timer_count;
            ctr_drop_r <= dropped_frame_counter;
            data_out <= (bus16 && rd_hi_r) ? {{(DW/2){1'b0}}, rd_val[DW-1:DW/2]} : rd_val;
            if (addr == `AHP_OFF_RX_DATA && bus16) begin
              rd_hi_r <= !rd_hi_r;
            end
            rx_status_pop <= (addr == `AHP_OFF_RX_STAT);
            tx_status_pop <= (addr == `AHP_OFF_TX_STAT);
          end else if (wr_act) begin
            state_r <= ST_WRITE;
            if (addr == `AHP_OFF_RX_DATA) begin
              tx_data_push <= 1'b1;
              tx_data_word <= data_in;
            end
          end
        end
        ST_READ: begin
          if (!rd_act) begin
            state_r <= ST_IDLE;
          end else if (addr_step) begin
            addr_r <= addr;
            beat_r <= beat_r + 5'h1;
            if (beat_r >= beat_max) begin
              burst_overrun <= 1'b1;
            end
            data_out <= (bus16 && rd_hi_r) ? {{(DW/2){1'b0}}, rd_val[DW-1:DW/2]} : rd_val;
            if (addr == `AHP_OFF_RX_DATA && bus16) begin
              rd_hi_r <= !rd_hi_r;
            end
          end
        end
        ST_WRITE: begin
          if (!wr_act) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // transmit fill level, refreshed a fixed delay after a push
  // ------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      txf_wait_r <= 4'h0;
      txf_pend_r <= 1'b0;
      transmit_fill_info <= {DW{1'b0}};
    end else begin
      if (tx_data_push) begin
        txf_pend_r <= 1'b1;
        txf_wait_r <= TXF_LOAD[3:0];
      end else if (txf_pend_r) begin
        if (txf_wait_r <= 4'h1) begin
          txf_pend_r <= 1'b0;
          transmit_fill_info <= {{(DW-16){1'b0}}, tx_free_space};
        end else begin
          txf_wait_r <= txf_wait_r - 4'h1;
        end
      end else begin
        transmit_fill_info <= {{(DW-16){1'b0}}, tx_free_space};
      end
    end
  end
endmodule
`default_nettype wire

// [tb/ahp_port_assertions.sv]
// ahp_port_assertions.sv: strobe and lane checker for the host read port
// assumes binding onto ahp_port at its default 32-bit width
`timescale 1ns/10ps
`default_nettype none
`include "ahp_map.vh"
module ahp_port_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_low,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic [5:0] addr,
  input wire logic bus16,
  input wire logic [31:0] data_out,
  input wire logic [31:0] data_oe,
  input wire logic [31:0] free_counter,
  input wire logic rx_status_pop,
  input wire logic tx_status_pop,
  input wire logic tx_data_push,
  input wire logic [15:0] tx_free_space,
  input wire logic [31:0] transmit_fill_info
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_on = !chip_select_low && !read_strobe_low;
  wire wr_on = !chip_select_low && !write_strobe_low;
  sequence rd_go;
    rd_on && !$past(rd_on);
  endsequence
  chk_oe_rise: assert property (rd_go |=> data_oe[15:0] == 16'hFFFF)
    else $error("read lanes not driven after start");
  chk_oe_fall: assert property (rd_on ##1 !rd_on |=> data_oe == 32'h0)
    else $error("lanes still driven after strobe release");
  chk_upper_off: assert property (bus16 |-> data_oe[31:16] == 16'h0)
    else $error("upper lanes driven on narrow bus");
  chk_full_lanes: assert property (!bus16 && data_oe != 32'h0 |-> data_oe == 32'hFFFFFFFF)
    else $error("partial lanes on wide bus");
  chk_count_latch: assert property ((rd_go ##0 addr == `AHP_OFF_FREE_CNT)
    |=> data_out == $past(free_counter))
    else $error("counter not taken at cycle start");
  chk_rx_pop: assert property ((rd_go ##0 addr == `AHP_OFF_RX_STAT)
    |=> rx_status_pop ##1 !rx_status_pop)
    else $error("rx status pop missing");
  chk_tx_pop: assert property ((rd_go ##0 addr == `AHP_OFF_TX_STAT)
    |=> tx_status_pop ##1 !tx_status_pop)
    else $error("tx status pop missing");
  chk_tx_push: assert property (wr_on && !$past(wr_on) && addr == 6'h00
    |=> tx_data_push ##1 !tx_data_push)
    else $error("tx data push missing");
  chk_fill_update: assert property (tx_data_push
    |-> ##[1:2] transmit_fill_info == {16'h0000, tx_free_space})
    else $error("transmit fill level not refreshed after push");
  cover property (rd_go ##0 bus16);
  cover property (tx_data_push);
  cover property (rx_status_pop);
endmodule
bind ahp_port ahp_port_chk u_ahp_port_chk (
  .clk(clk),
  .rst(rst),
  .chip_select_low(chip_select_low),
  .read_strobe_low(read_strobe_low),
  .write_strobe_low(write_strobe_low),
  .addr(addr),
  .bus16(bus16),
  .data_out(data_out),
  .data_oe(data_oe),
  .free_counter(free_counter),
  .rx_status_pop(rx_status_pop),
  .tx_status_pop(tx_status_pop),
  .tx_data_push(tx_data_push),
  .tx_free_space(tx_free_space),
  .transmit_fill_info(transmit_fill_info)
);
`default_nettype wire

// [tb/ahp_host.sv]
// ahp_host.sv: host processor model driving the sram-like strobes
// assumes clk from the bench; drives 1 ns after rising edges
`timescale 1ns/10ps
`default_nettype none
`include "ahp_map.vh"
module ahp_host (
  input wire logic clk,
  output logic chip_select_low,
  output logic read_strobe_low,
  output logic write_strobe_low,
  output logic [5:0] addr,
  output logic [31:0] data_in,
  input wire logic [31:0] data_out
);
  initial begin
    chip_select_low = 1;
    read_strobe_low = 1;
    write_strobe_low = 1;
    addr = 0;
    data_in = 0;
  end
  task automatic rel();
    chip_select_low = 1;
    read_strobe_low = 1;
    write_strobe_low = 1;
    @(posedge clk) #1;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    addr = a;
    chip_select_low = 0;
    read_strobe_low = 0;
    repeat (2) @(posedge clk);
    #1 v = data_out;
    rel();
  endtask
  task automatic burst(input int n);
    chip_select_low = 0;
    read_strobe_low = 0;
    for (int i = 0; i < n; i++) begin
      addr = i[0] ? `AHP_OFF_ENDIAN : `AHP_OFF_CHIP_ID;
      @(posedge clk) #1;
    end
    rel();
  endtask
  task automatic wr(input logic [31:0] d);
    addr = `AHP_OFF_RX_DATA;
    data_in = d;
    chip_select_low = 0;
    write_strobe_low = 0;
    @(posedge clk) #1;
    data_in = ~d;
    rel();
  endtask
  // waits whole cycles, the delay rounded up to 50 ns clock periods
  task automatic hold_off(input int ns);
    repeat ((ns + 49) / 50) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// [tb/ahp_port_bench.sv]
// ahp_port_bench.sv: self-checking bench for the host read port
// assumes ahp_host as far side and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "ahp_map.vh"
module ahp_port_bench;
  logic clk, rst, cs_low, rd_low, wr_low, bus16, rx_in_valid, rx_in_ready, burst_overrun;
  logic tx_push;
  logic [5:0] addr;
  logic [31:0] data_in, data_out, data_oe, rx_in_data, tx_data_word, v, t, tx_fill;
  logic [15:0] free_sp = 16'h0100;
  logic [31:0] base = 32'h5A000000;
  logic [31:0] tick = 0;
  int errors = 0;
  int check_count = 0;
  localparam logic [5:0] RA [8] = '{6'h14, 6'h15, 6'h16, 6'h21, 6'h24, 6'h28, 6'h10, 6'h12};
  localparam logic [31:0] RK [8] = '{32'h11, 32'h22, 32'h33, 32'h44, 32'h55, 32'h66,
    32'h77, 32'h88};
  ahp_port u_ahp_port (.clk(clk), .rst(rst), .chip_select_low(cs_low),
    .read_strobe_low(rd_low), .write_strobe_low(wr_low), .addr(addr), .bus16(bus16),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .rx_in_valid(rx_in_valid),
    .rx_in_ready(rx_in_ready), .rx_in_data(rx_in_data), .rx_status_word(base ^ RK[6]),
    .tx_status_word(base ^ RK[7]), .rx_status_pop(), .tx_status_pop(), .tx_data_push(tx_push),
    .tx_data_word(tx_data_word), .tx_free_space(free_sp),
    .chip_identity(base ^ RK[0]), .irq_line_config(base ^ RK[1]),
    .interrupt_flags(base ^ RK[2]), .power_manage_control(base ^ RK[3]),
    .general_timer_count(base ^ RK[4]), .free_counter(tick),
    .dropped_frame_counter(base ^ RK[5]), .transmit_fill_info(tx_fill),
    .burst_overrun(burst_overrun));
  ahp_host u_ahp_host (.clk(clk), .chip_select_low(cs_low), .read_strobe_low(rd_low),
    .write_strobe_low(wr_low), .addr(addr), .data_in(data_in), .data_out(data_out));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) tick <= tick + 1;
  // stands in for the transmit fifo: one word of space used per push
  always @(posedge clk) if (tx_push) free_sp <= free_sp - 16'h0001;
  initial begin
    #500000;
    errors++;
    conclude();
  end
  initial begin
    rst = 1;
    bus16 = 0;
    rx_in_valid = 0;
    rx_in_data = 0;
    repeat (6) @(posedge clk);
    #1 rst = 0;
    chk("oe", data_oe, 0);
    chk("ready", rx_in_ready, 1);
    for (int i = 0; i < 8; i++) begin
      u_ahp_host.rd(RA[i], v);
      chk("reg", v, base ^ RK[i]);
    end
    u_ahp_host.rd(`AHP_OFF_ENDIAN, v);
    chk("endian", v, `AHP_ENDIAN_VAL);
    u_ahp_host.rd(6'h3F, v);
    chk("unmapped", v, 0);
    t = tick;
    u_ahp_host.rd(`AHP_OFF_FREE_CNT, v);
    chk("counter", v, t);
    $display("test registers done");
    rx_in_valid = 1;
    for (int i = 0; i < 16; i++) begin
      rx_in_data = 32'(i);
      @(posedge clk) #1;
    end
    chk("full", rx_in_ready, 0);
    rx_in_valid = 0;
    for (int i = 0; i < 17; i++) begin
      u_ahp_host.rd(`AHP_OFF_RX_DATA, v);
      chk("fifo", v, i < 16 ? 32'(i) : 0);
    end
    $display("test fifo done");
    bus16 = 1;
    rx_in_valid = 1;
    rx_in_data = 32'hCAFEBABE;
    @(posedge clk) #1;
    rx_in_valid = 0;
    u_ahp_host.rd(`AHP_OFF_RX_DATA, v);
    chk("low half", {16'h0, v[15:0]}, 32'hBABE);
    u_ahp_host.rd(`AHP_OFF_RX_DATA, v);
    chk("high half", {16'h0, v[15:0]}, 32'hCAFE);
    $display("test narrow done");
    for (int k = 0; k < 4; k++) begin
      bus16 = k[1];
      u_ahp_host.burst((k[1] ? 16 : 8) + k[0]);
      chk("overrun", {31'h0, burst_overrun}, 32'(k[0]));
    end
    $display("test burst done");
    bus16 = 0;
    u_ahp_host.wr(32'h1234ABCD);
    chk("tx word", tx_data_word, 32'h1234ABCD);
    u_ahp_host.hold_off(`AHP_TX_FILL_NS);
    u_ahp_host.rd(`AHP_OFF_TX_FILL, v);
    chk("tx fill read", v, 32'h000000FF);
    chk("tx fill port", tx_fill, 32'h000000FF);
    rst = 1;
    @(posedge clk) #1;
    rst = 0;
    chk("oe", data_oe, 0);
    chk("data after reset", data_out, 0);
    chk("fill after reset", tx_fill, 0);
    $display("test write and reset done");
    conclude();
  end
endmodule
`default_nettype wire
